// File: verilog/mram_host_pkg.sv
// Package: register map, pin codes and timing for the MRAM host controller
package mram_host_pkg;
  // ---------------------------------------------------------------
  // Device configuration register offsets (word index in config space)
  // ---------------------------------------------------------------
  localparam logic [3:0] ECC_CONTROL_IDX = 4'h0;
  localparam logic [3:0] DRIVE_STRENGTH_CONFIG_IDX = 4'h1;
  localparam logic [3:0] WRITE_PROTECT_CONFIG_IDX = 4'h2;
  localparam int ECC_COUNT_CLEAR_BIT = 0;
  localparam int ECC_ALERT_CLEAR_BIT = 1;
  localparam int DRIVE_ENABLE_BIT = 2;
  localparam logic [2:0] PROTECT_NONE = 3'h0;
  localparam logic [2:0] PROTECT_ALL = 3'h7;
  localparam logic [31:0] DRIVE_STRENGTH_RESET = 32'h0;
  localparam logic [31:0] WRITE_PROTECT_RESET = 32'h0;
  // ---------------------------------------------------------------
  // Host command registers (software side)
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_ADDR_REG = 4'h0;
  localparam logic [3:0] CMD_WDATA_REG = 4'h4;
  localparam logic [3:0] CMD_CTRL_REG = 4'h8;
  localparam logic [3:0] CMD_STATUS_REG = 4'hC;
  localparam logic [3:0] CMD_RDATA_REG = 4'h1;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_CFG_BIT = 2;
  localparam int CTRL_BANK_BIT = 3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ = 40000000;
  localparam int POWERUP_WAIT_TIME_US = 1000;
  localparam int POWERUP_WAIT_CYCLES = (CLOCK_HZ / 1000000) * POWERUP_WAIT_TIME_US;
  localparam int ACCESS_CYCLES = 4;
  localparam int SYNC_STAGES = 3;
endpackage

// File: verilog/mram_host.sv
// MRAM host controller: drives the device pins on orders from software
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module mram_host #(
  parameter int ADDR_W = 27,
  parameter int POWERUP_CYCLES = mram_host_pkg::POWERUP_WAIT_CYCLES,
  parameter int ACCESS_CYC = mram_host_pkg::ACCESS_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Software port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Device pins
  output logic bank_one_select_n_o,
  output logic bank_two_select_n_o,
  output logic config_space_select_n_o,
  output logic output_enable_n_o,
  output logic write_strobe_n_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [31:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [31:0] dq_i,
  input wire logic alert_n_i
);
  import mram_host_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h1,
    ST_IDLE = 4'h2,
    ST_ACCESS = 4'h4,
    ST_DONE = 4'h8
  } state_t;

  state_t state_ff;
  logic [31:0] wait_cnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic write_ff;
  logic cfg_ff;
  logic bank_ff;
  logic [2:0] alert_sync_ff;
  logic alert_ff;
  logic go;

  assign go = reg_wr_i && (reg_addr_i == CMD_CTRL_REG) && reg_wdata_i[CTRL_GO_BIT]
              && (state_ff == ST_IDLE);

  // ---------------------------------------------------------------
  // Alert input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alert_sync_ff <= 3'h7;
      alert_ff <= 1'b0;
    end else begin
      alert_sync_ff <= {alert_sync_ff[1:0], alert_n_i};
      // Level counts once stages two and three agree
      if (alert_sync_ff[1] == alert_sync_ff[2]) begin
        alert_ff <= !alert_sync_ff[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Command registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_ff <= '0;
      wdata_ff <= 32'h0;
      write_ff <= 1'b0;
      cfg_ff <= 1'b0;
      bank_ff <= 1'b0;
    end else if (reg_wr_i && state_ff == ST_IDLE) begin
      // Top two address bits pick the die; software owns them
      if (reg_addr_i == CMD_ADDR_REG) addr_ff <= reg_wdata_i[ADDR_W-1:0];
      if (reg_addr_i == CMD_WDATA_REG) wdata_ff <= reg_wdata_i;
      if (reg_addr_i == CMD_CTRL_REG) begin
        write_ff <= reg_wdata_i[CTRL_WRITE_BIT];
        cfg_ff <= reg_wdata_i[CTRL_CFG_BIT];
        bank_ff <= reg_wdata_i[CTRL_BANK_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_POWERUP;
      wait_cnt_ff <= 32'h0;
    end else begin
      case (state_ff)
        ST_POWERUP: begin
          // Selects stay high until the power-up delay has run out
          if (wait_cnt_ff == 32'(POWERUP_CYCLES - 1)) begin
            state_ff <= ST_IDLE;
            wait_cnt_ff <= 32'h0;
          end else begin
            wait_cnt_ff <= wait_cnt_ff + 32'h1;
          end
        end
        ST_IDLE: begin
          if (go) state_ff <= ST_ACCESS;
        end
        ST_ACCESS: begin
          if (wait_cnt_ff == 32'(ACCESS_CYC - 1)) begin
            state_ff <= ST_DONE;
            wait_cnt_ff <= 32'h0;
          end else begin
            wait_cnt_ff <= wait_cnt_ff + 32'h1;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_POWERUP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_one_select_n_o <= 1'b1;
      bank_two_select_n_o <= 1'b1;
      config_space_select_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      mem_addr_o <= '0;
      dq_o <= 32'h0;
      dq_oe_n_o <= 1'b1;
    end else if (state_ff == ST_ACCESS) begin
      // Only one bank select ever goes low
      bank_one_select_n_o <= bank_ff;
      bank_two_select_n_o <= !bank_ff;
      config_space_select_n_o <= !cfg_ff;
      mem_addr_o <= addr_ff;
      // Write strobe released in the last cycle so address and data hold past it
      write_strobe_n_o <= !(write_ff && wait_cnt_ff != 32'(ACCESS_CYC - 1));
      output_enable_n_o <= write_ff;
      dq_o <= wdata_ff;
      dq_oe_n_o <= !write_ff;
    end else begin
      bank_one_select_n_o <= 1'b1;
      bank_two_select_n_o <= 1'b1;
      config_space_select_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      dq_oe_n_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read capture and software read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h0;
    end else if (state_ff == ST_ACCESS && !write_ff && wait_cnt_ff == 32'(ACCESS_CYC - 1)) begin
      rdata_ff <= dq_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CMD_ADDR_REG: reg_rdata_o <= 32'(addr_ff);
        CMD_WDATA_REG: reg_rdata_o <= wdata_ff;
        CMD_CTRL_REG: reg_rdata_o <= {28'h0, bank_ff, cfg_ff, write_ff, 1'b0};
        // Alert shown so software can walk the dies and clear flags
        CMD_STATUS_REG: reg_rdata_o <= {28'h0, alert_ff, state_ff == ST_POWERUP,
                                        state_ff != ST_IDLE, state_ff == ST_IDLE};
        CMD_RDATA_REG: reg_rdata_o <= rdata_ff;
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_go;
    state_ff == ST_IDLE && go;
  endsequence

  a_bank_exclusive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !(!bank_one_select_n_o && !bank_two_select_n_o))
    else $error("both bank selects low");
  a_powerup_deselect: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_ff == ST_POWERUP |=> bank_one_select_n_o && bank_two_select_n_o)
    else $error("select low during power-up");
  a_powerup_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(state_ff == ST_IDLE) && $past(state_ff) == ST_POWERUP
    |-> $past(wait_cnt_ff) == 32'(POWERUP_CYCLES - 1))
    else $error("power-up wait too short");
  a_write_pins: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !write_strobe_n_o |-> !dq_oe_n_o && output_enable_n_o)
    else $error("write strobe without data drive");
  a_read_pins: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !output_enable_n_o |-> write_strobe_n_o && dq_oe_n_o)
    else $error("read with host driving data");
  a_no_drive_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    bank_one_select_n_o && bank_two_select_n_o |-> dq_oe_n_o)
    else $error("data driven while deselected");
  a_access_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_go |-> ##2 (!bank_one_select_n_o || !bank_two_select_n_o))
    else $error("access did not start");
  a_cfg_select: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !config_space_select_n_o |-> !bank_one_select_n_o || !bank_two_select_n_o)
    else $error("config select without chip select");
endmodule

// File: verification/mram_dev_model.sv
// Behavioural model of the persistent memory device
`timescale 1ns/100ps
module mram_dev_model (
  // Pins from host
  input wire logic bank_one_select_n_i,
  input wire logic bank_two_select_n_i,
  input wire logic config_space_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [26:0] mem_addr_i,
  input wire logic [31:0] dq_i,
  input wire logic dq_oe_n_i,
  input wire logic inject_err_i,
  // Pins to host
  output logic [31:0] dq_o,
  output logic alert_n_o
);
  logic [31:0] mem [logic [27:0]];
  logic [2:0] drv [8];
  logic [2:0] prot [8];
  logic [7:0] flag = 8'h0;
  logic [31:0] rd_val;
  logic [31:0] hold = 32'h0;
  logic sel;
  logic [2:0] die;
  logic [27:0] key;
  assign sel = !bank_one_select_n_i || !bank_two_select_n_i;
  assign die = {bank_one_select_n_i, mem_addr_i[26:25]};
  assign key = {bank_one_select_n_i, mem_addr_i};
  assign alert_n_o = (flag == 8'h0);
  initial for (int i = 0; i < 8; i++) begin
    drv[i] = 3'h0;
    prot[i] = 3'h0;
  end
  always @* begin
    rd_val = 32'h0;
    if (!config_space_select_n_i) begin
      if (mem_addr_i[3:0] == 4'h1) rd_val = {29'h0, drv[die]};
      if (mem_addr_i[3:0] == 4'h2) rd_val = {29'h0, prot[die]};
    end else if (mem.exists(key)) rd_val = mem[key];
  end
  // Undriven DQ has no pull, so it shows the inverse of the last value
  always @* begin
    if (!dq_oe_n_i) begin
      dq_o = dq_i;
      hold = dq_i;
    end else if (sel && !output_enable_n_i && write_strobe_n_i) begin
      dq_o = rd_val;
      hold = rd_val;
    end else dq_o = ~hold;
  end
  always @(posedge write_strobe_n_i) if (sel) begin
    if (!config_space_select_n_i) begin
      case (mem_addr_i[3:0])
        4'h0: if (dq_i[1]) flag[die] <= 1'h0;
        4'h1: drv[die] <= dq_i[2:0];
        4'h2: prot[die] <= dq_i[2:0];
        default: ;
      endcase
    end else if (prot[die] == 3'h0 ||
        (mem_addr_i[24:0] >> (18 + prot[die])) != ((1 << (7 - prot[die])) - 1))
      mem[key] = dq_i;
  end
  // Latched until cleared through the control register
  always @(negedge output_enable_n_i)
    if (sel && config_space_select_n_i && inject_err_i) flag[die] <= 1'h1;
endmodule

// File: verification/mram_host_test.sv
// Self-checking bench for the memory host controller
`timescale 1ns/100ps
module mram_host_test;
  import mram_host_pkg::*;
  logic clock_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic inject = 1'h0;
  logic [31:0] reg_rdata_o, dq_o, dq_i, v, hi, lo;
  logic b1_n, b2_n, cfg_n, oe_n, we_n, dq_oe_n, alert_n;
  logic [26:0] mem_addr;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 clock_i = ~clock_i;
  mram_host #(.POWERUP_CYCLES(8)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bank_one_select_n_o(b1_n),
    .bank_two_select_n_o(b2_n), .config_space_select_n_o(cfg_n), .output_enable_n_o(oe_n),
    .write_strobe_n_o(we_n), .mem_addr_o(mem_addr), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n),
    .dq_i(dq_i), .alert_n_i(alert_n));
  mram_dev_model dev (.bank_one_select_n_i(b1_n), .bank_two_select_n_i(b2_n),
    .config_space_select_n_i(cfg_n), .output_enable_n_i(oe_n), .write_strobe_n_i(we_n),
    .mem_addr_i(mem_addr), .dq_i(dq_o), .dq_oe_n_i(dq_oe_n), .inject_err_i(inject),
    .dq_o(dq_i), .alert_n_o(alert_n));
  task finish_test;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run needs under two thousand cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      finish_test;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge clock_i);
    reg_wr_i <= 1'h0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge clock_i);
    reg_rd_i <= 1'h0;
    @(negedge clock_i);
    d = reg_rdata_o;
  endtask
  // Control nibble: bank, config, write, go
  task acc(input logic [3:0] ctl, input logic [31:0] a, input logic [31:0] d);
    wr(CMD_ADDR_REG, a);
    wr(CMD_WDATA_REG, d);
    wr(CMD_CTRL_REG, {28'h0, ctl});
    repeat (3) @(posedge clock_i);
    for (int n = 0; n < 40; n++) begin
      rd(CMD_STATUS_REG, v);
      if (v[0] === 1'h1) break;
    end
    chk(v[0], 1'h1);
    rd(CMD_RDATA_REG, v);
  endtask
  function automatic logic [31:0] cfga(input logic [1:0] d, input logic [3:0] i);
    return {5'h0, d, 21'h0, i};
  endfunction
  task status_alert(input logic exp);
    repeat (6) @(posedge clock_i);
    rd(CMD_STATUS_REG, v);
    chk(v[3], exp);
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'h1;
    rd(CMD_STATUS_REG, v);
    chk(v[2], 1'h1);
    chk(b1_n & b2_n, 1'h1);
    // Eight power-up cycles: busy at the eighth edge, idle two edges later
    rd(CMD_STATUS_REG, v);
    rd(CMD_STATUS_REG, v);
    rd(CMD_STATUS_REG, v);
    chk(v[2:0], 3'h6);
    rd(CMD_STATUS_REG, v);
    chk(v[2:0], 3'h1);
    acc(4'h5, cfga(0, 1), 32'h0);
    chk(v, DRIVE_STRENGTH_RESET);
    rd(CMD_CTRL_REG, v);
    chk(v, 32'h4);
    rd(CMD_ADDR_REG, v);
    chk(v, cfga(0, 1));
    acc(4'h5, cfga(0, 2), 32'h0);
    chk(v, WRITE_PROTECT_RESET);
    acc(4'h7, cfga(0, 1), 32'hFFFFFFFF);
    acc(4'h3, 32'h1, 32'h0);
    acc(4'h5, cfga(0, 1), 32'h0);
    chk(v, 32'h7);
    acc(4'h3, 32'h10, 32'hA5A5A5A5);
    acc(4'hB, 32'h10, 32'h5A5A5A5A);
    acc(4'h1, 32'h10, 32'h0);
    chk(v, 32'hA5A5A5A5);
    acc(4'h9, 32'h10, 32'h0);
    chk(v, 32'h5A5A5A5A);
    hi = 32'h01FFFFFF;
    for (int p = 1; p < 8; p++) begin
      lo = (p < 7) ? hi ^ (32'h1 << (18 + p)) : hi ^ 32'h1;
      acc(4'h7, cfga(0, 2), 32'h0);
      acc(4'h3, hi, 32'h11);
      acc(4'h3, lo, 32'h11);
      acc(4'h7, cfga(0, 2), 32'hFFFFFFF8 | p);
      acc(4'h3, hi, 32'h22);
      acc(4'h3, lo, 32'h22);
      acc(4'h1, hi, 32'h0);
      chk(v, 32'h11);
      acc(4'h1, lo, 32'h0);
      chk(v, (p == 7) ? 32'h11 : 32'h22);
      acc(4'h5, cfga(0, 2), 32'h0);
      chk(v, p);
    end
    acc(4'h5, cfga(1, 2), 32'h0);
    chk(v, 32'h0);
    acc(4'h3, 32'h03FFFFFF, 32'h33);
    acc(4'h1, 32'h03FFFFFF, 32'h0);
    chk(v, 32'h33);
    inject <= 1'h1;
    acc(4'h1, 32'h10, 32'h0);
    inject <= 1'h0;
    status_alert(1'h1);
    acc(4'h7, cfga(0, 0), 32'h1);
    status_alert(1'h1);
    acc(4'h7, cfga(0, 0), 32'h2);
    status_alert(1'h0);
    finish_test;
  end
endmodule
